// *** fsp_consts.vh ***
// constants for the dual programmable-flag fifo
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// data word width
`define FSP_DATA_W 9
// offset register width
`define FSP_OFS_W 8
// default depth of one channel
`define FSP_DEPTH_DEF 256
// default empty and full offsets when nothing is programmed
`define FSP_EMPTY_OFS_DEF 8'h07
`define FSP_FULL_OFS_DEF 8'h07
// offset register order in the load and read-back sequence
`define FSP_SEL_EMPTY_LO 2'h0
`define FSP_SEL_EMPTY_HI 2'h1
`define FSP_SEL_FULL_LO 2'h2
`define FSP_SEL_FULL_HI 2'h3
// flag levels while reset is held
`define FSP_FULL_RST 1'b1
`define FSP_AFULL_RST 1'b1
`define FSP_EMPTY_RST 1'b0
`define FSP_AEMPTY_RST 1'b0
// data output register value at reset
`define FSP_DOUT_RST 9'h000
// least skew between clock edges for a flag to change in the same cycle
`define FSP_SKEW_MIN_NS 5
`define FSP_SYS_CLK_NS 50
`define FSP_SKEW_MIN_CYC \
   (((`FSP_SKEW_MIN_NS + `FSP_SYS_CLK_NS - 1) / `FSP_SYS_CLK_NS) < 1 ? 1 : \
   ((`FSP_SKEW_MIN_NS + `FSP_SYS_CLK_NS - 1) / `FSP_SYS_CLK_NS))

`endif

// *** fsp_dual_fifo.v ***
// dual 9-bit fifo with programmable almost-empty and almost-full flags
// Function
// R1: pin high during reset makes it a second active-high write enable.
// R2: dual-enable mode writes when primary enable low and second enable high.
// R3: dual-enable mode holds input register otherwise, nothing written.
// R4: full array forces full flag low and ignores all write enables.
// R5: a read freeing a full array raises full flag on write clock.
// R6: pin low during reset selects programmable flags, pin loads offsets.
// R7: four 8-bit offset registers per channel, loadable and readable.
// R8: load-low writes go empty lo, empty hi, full lo, full hi, wrap.
// R9: sequence position survives raising load; next load continues onward.
// R10: load low and reads enabled present offsets in the same order.
// R11: controller must not read and write offsets simultaneously.
// R12: full flag low when count equals depth, updated on write clock.
// R13: empty flag low when pointers equal, updated on read clock.
// R14: almost-full low at depth minus full offset, default seven.
// R15: almost-empty low at n or fewer words, high from n+1.
// R16: unprogrammed empty offset defaults to seven words.
// R17: flags follow the word-count map from empty through full.
// R18: data outputs low with enable 0 after reset, released with 1.
// R19: clocks may run freely while reset is held.
// R20: full flag update may slip to next write clock edge.
// R21: empty flag update may slip to next read clock edge.
// R22: reset clears pointers, output register, offsets, sets flag levels; code loads both low offset bytes with seven and clears the high bytes.
// R23: array word moves to output only with both read enables low.
// R24: programmable mode gates array writes with primary enable alone; code also needs the load pin high.
// R25: two identical independent channels.
// R26: pointers compared without unsafe crossings so flags never lie.
// R27: offset bytes concatenate into a threshold cut to depth width.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.vh"

module fsp_channel #(
   parameter DEPTH = `FSP_DEPTH_DEF,
   parameter AW = 8
) (
   input wire sys_clk,
   input wire nrst,
   input wire chan_reset_n,
   input wire write_clock,
   input wire read_clock,
   input wire primary_write_enable_n,
   input wire second_enable_or_load_n,
   input wire read_enable_first_n,
   input wire read_enable_second_n,
   input wire output_drive_enable_n,
   input wire [`FSP_DATA_W-1:0] write_data_in,
   output reg [`FSP_DATA_W-1:0] read_data_out,
   output reg read_data_oe_n,
   output reg full_flag_n,
   output reg empty_flag_n,
   output reg almost_full_n,
   output reg almost_empty_n
);
   localparam [AW:0] DEPTH_CNT = DEPTH[AW:0];

   // joins a high and low offset byte into a threshold of pointer width
   function [AW:0] fsp_thresh;
      input [`FSP_OFS_W-1:0] hi;
      input [`FSP_OFS_W-1:0] lo;
      reg [2*`FSP_OFS_W+AW:0] wide;
      begin
         wide = {{(AW+1){1'b0}}, hi, lo};
         fsp_thresh = {1'b0, wide[AW-1:0]}; // R27
      end
   endfunction

   reg [`FSP_DATA_W-1:0] mem [0:DEPTH-1];
   reg [AW:0] wptr;
   reg [AW:0] rptr;
   reg [`FSP_OFS_W-1:0] ofs [0:3];
   reg [1:0] ofs_sel;
   reg prog_mode;
   reg wclk_q;
   reg rclk_q;
   wire rst_n;
   wire wr_edge;
   wire rd_edge;
   wire load_n;
   wire wr_word;
   wire wr_ofs;
   wire rd_word;
   wire rd_ofs;
   wire [AW:0] next_wptr;
   wire [AW:0] next_rptr;
   wire [AW:0] next_cnt;
   wire [AW:0] empty_th;
   wire [AW:0] full_th;

   assign rst_n = nrst & chan_reset_n;
   // clock pins are sampled inputs; rising edges found against last sample
   assign wr_edge = write_clock & ~wclk_q;
   assign rd_edge = read_clock & ~rclk_q; // R19
   assign load_n = second_enable_or_load_n;

   // write and read qualification per configuration
   assign wr_word = wr_edge & full_flag_n & ~primary_write_enable_n &
      (prog_mode ? load_n : load_n); // R2 R3 R4 R24
   assign wr_ofs = wr_edge & prog_mode & ~load_n &
      ~primary_write_enable_n; // R8
   assign rd_word = rd_edge & empty_flag_n & ~read_enable_first_n &
      ~read_enable_second_n & ~(prog_mode & ~load_n); // R23 R13
   assign rd_ofs = rd_edge & prog_mode & ~load_n & ~read_enable_first_n &
      ~read_enable_second_n; // R10 R11

   // pointers and count all live in one domain, no crossing needed
   assign next_wptr = wr_word ? wptr + {{AW{1'b0}}, 1'b1} : wptr;
   assign next_rptr = rd_word ? rptr + {{AW{1'b0}}, 1'b1} : rptr;
   assign next_cnt = next_wptr - next_rptr; // R26
   assign empty_th = fsp_thresh(ofs[`FSP_SEL_EMPTY_HI],
      ofs[`FSP_SEL_EMPTY_LO]);
   assign full_th = fsp_thresh(ofs[`FSP_SEL_FULL_HI],
      ofs[`FSP_SEL_FULL_LO]);

   // clock pin samples for edge detection
   always @(posedge sys_clk) begin
      wclk_q <= write_clock;
      rclk_q <= read_clock;
   end

   // configuration caught while reset is held
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         prog_mode <= ~second_enable_or_load_n; // R1 R6
      end
   end

   // array write, only on a qualified write edge
   always @(posedge sys_clk) begin
      if (wr_word) begin
         mem[wptr[AW-1:0]] <= write_data_in; // R2 R24
      end
   end

   // pointers
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         wptr <= {(AW+1){1'b0}}; // R22
         rptr <= {(AW+1){1'b0}};
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
   end

   // offset registers and shared sequence position
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ofs[`FSP_SEL_EMPTY_LO] <= `FSP_EMPTY_OFS_DEF; // R16 R22
         ofs[`FSP_SEL_EMPTY_HI] <= 8'h00;
         ofs[`FSP_SEL_FULL_LO] <= `FSP_FULL_OFS_DEF; // R14
         ofs[`FSP_SEL_FULL_HI] <= 8'h00;
         ofs_sel <= `FSP_SEL_EMPTY_LO;
      end else if (wr_ofs) begin
         ofs[ofs_sel] <= write_data_in[`FSP_OFS_W-1:0]; // R7 R8
         ofs_sel <= ofs_sel + 2'h1; // R8 R9
      end else if (rd_ofs) begin
         ofs_sel <= ofs_sel + 2'h1; // R10
      end
   end

   // output register and drive enable
   always @(posedge sys_clk) begin
      read_data_oe_n <= output_drive_enable_n; // R18
      if (!rst_n) begin
         read_data_out <= `FSP_DOUT_RST; // R18 R22
      end else if (rd_ofs) begin
         read_data_out <= {1'b0, ofs[ofs_sel]}; // R10
      end else if (rd_word) begin
         read_data_out <= mem[rptr[AW-1:0]]; // R23
      end
   end

   // write-side flags, refreshed only on write clock edges
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         full_flag_n <= `FSP_FULL_RST; // R22
         almost_full_n <= `FSP_AFULL_RST;
      end else if (wr_edge) begin
         full_flag_n <= ~(next_cnt == DEPTH_CNT); // R12 R5 R20
         almost_full_n <= ~(next_cnt >= DEPTH_CNT - full_th); // R14 R17
      end
   end

   // read-side flags, refreshed only on read clock edges
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         empty_flag_n <= `FSP_EMPTY_RST; // R22
         almost_empty_n <= `FSP_AEMPTY_RST;
      end else if (rd_edge) begin
         empty_flag_n <= (next_wptr != next_rptr); // R13 R21
         almost_empty_n <= (next_cnt > empty_th); // R15 R16 R17
      end
   end
endmodule // fsp_channel

module fsp_dual_fifo #(
   parameter DEPTH = `FSP_DEPTH_DEF,
   parameter AW = 8
) (
   input wire SYS_CLK,
   input wire NRST,
   input wire CHANNEL_RESET_N,
   input wire WRITE_CLOCK,
   input wire READ_CLOCK,
   input wire PRIMARY_WRITE_ENABLE_N,
   input wire SECOND_ENABLE_OR_LOAD_N,
   input wire READ_ENABLE_FIRST_N,
   input wire READ_ENABLE_SECOND_N,
   input wire OUTPUT_DRIVE_ENABLE_N,
   input wire [`FSP_DATA_W-1:0] WRITE_DATA_IN,
   output wire [`FSP_DATA_W-1:0] READ_DATA_OUT,
   output wire READ_DATA_OE_N,
   output wire FULL_FLAG_N,
   output wire EMPTY_FLAG_N,
   output wire ALMOST_FULL_N,
   output wire ALMOST_EMPTY_N,
   input wire CHANNEL_RESET_N_CHAN_B,
   input wire WRITE_CLOCK_CHAN_B,
   input wire READ_CLOCK_CHAN_B,
   input wire PRIMARY_WRITE_ENABLE_N_CHAN_B,
   input wire SECOND_ENABLE_OR_LOAD_N_CHAN_B,
   input wire READ_ENABLE_FIRST_N_CHAN_B,
   input wire READ_ENABLE_SECOND_N_CHAN_B,
   input wire OUTPUT_DRIVE_ENABLE_N_CHAN_B,
   input wire [`FSP_DATA_W-1:0] WRITE_DATA_IN_CHAN_B,
   output wire [`FSP_DATA_W-1:0] READ_DATA_OUT_CHAN_B,
   output wire READ_DATA_OE_N_CHAN_B,
   output wire FULL_FLAG_N_CHAN_B,
   output wire EMPTY_FLAG_N_CHAN_B,
   output wire ALMOST_FULL_N_CHAN_B,
   output wire ALMOST_EMPTY_N_CHAN_B
);
   // first of two independent channels
   fsp_channel #(.DEPTH(DEPTH), .AW(AW)) u_chan_a ( // R25
      .sys_clk(SYS_CLK),
      .nrst(NRST),
      .chan_reset_n(CHANNEL_RESET_N),
      .write_clock(WRITE_CLOCK),
      .read_clock(READ_CLOCK),
      .primary_write_enable_n(PRIMARY_WRITE_ENABLE_N),
      .second_enable_or_load_n(SECOND_ENABLE_OR_LOAD_N),
      .read_enable_first_n(READ_ENABLE_FIRST_N),
      .read_enable_second_n(READ_ENABLE_SECOND_N),
      .output_drive_enable_n(OUTPUT_DRIVE_ENABLE_N),
      .write_data_in(WRITE_DATA_IN),
      .read_data_out(READ_DATA_OUT),
      .read_data_oe_n(READ_DATA_OE_N),
      .full_flag_n(FULL_FLAG_N),
      .empty_flag_n(EMPTY_FLAG_N),
      .almost_full_n(ALMOST_FULL_N),
      .almost_empty_n(ALMOST_EMPTY_N)
   );

   // second channel, identical
   fsp_channel #(.DEPTH(DEPTH), .AW(AW)) u_chan_b ( // R25
      .sys_clk(SYS_CLK),
      .nrst(NRST),
      .chan_reset_n(CHANNEL_RESET_N_CHAN_B),
      .write_clock(WRITE_CLOCK_CHAN_B),
      .read_clock(READ_CLOCK_CHAN_B),
      .primary_write_enable_n(PRIMARY_WRITE_ENABLE_N_CHAN_B),
      .second_enable_or_load_n(SECOND_ENABLE_OR_LOAD_N_CHAN_B),
      .read_enable_first_n(READ_ENABLE_FIRST_N_CHAN_B),
      .read_enable_second_n(READ_ENABLE_SECOND_N_CHAN_B),
      .output_drive_enable_n(OUTPUT_DRIVE_ENABLE_N_CHAN_B),
      .write_data_in(WRITE_DATA_IN_CHAN_B),
      .read_data_out(READ_DATA_OUT_CHAN_B),
      .read_data_oe_n(READ_DATA_OE_N_CHAN_B),
      .full_flag_n(FULL_FLAG_N_CHAN_B),
      .empty_flag_n(EMPTY_FLAG_N_CHAN_B),
      .almost_full_n(ALMOST_FULL_N_CHAN_B),
      .almost_empty_n(ALMOST_EMPTY_N_CHAN_B)
   );
endmodule // fsp_dual_fifo
`default_nettype wire

// *** fsp_dual_fifo_properties.sv ***
// concurrent checks on channel A of the dual fifo top
`timescale 1ns/1ps
`default_nettype none
module fsp_dual_fifo_properties (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic CHANNEL_RESET_N,
   input wire logic WRITE_CLOCK,
   input wire logic READ_CLOCK,
   input wire logic SECOND_ENABLE_OR_LOAD_N,
   input wire logic READ_ENABLE_FIRST_N,
   input wire logic READ_ENABLE_SECOND_N,
   input wire logic OUTPUT_DRIVE_ENABLE_N,
   input wire logic [8:0] READ_DATA_OUT,
   input wire logic READ_DATA_OE_N,
   input wire logic FULL_FLAG_N,
   input wire logic EMPTY_FLAG_N,
   input wire logic ALMOST_FULL_N,
   input wire logic ALMOST_EMPTY_N
);
   // all checks on the system clock; all but the two reset checks quiet while a reset is held
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST || !CHANNEL_RESET_N);
   reset_levels_a: assert property (disable iff (1'h0)
      !NRST |=> FULL_FLAG_N && ALMOST_FULL_N && !EMPTY_FLAG_N
      && !ALMOST_EMPTY_N && READ_DATA_OUT == 9'h000) else $error("reset");
   chan_reset_a: assert property (disable iff (1'h0)
      !CHANNEL_RESET_N |=> FULL_FLAG_N && ALMOST_FULL_N && !EMPTY_FLAG_N
      && !ALMOST_EMPTY_N && READ_DATA_OUT == 9'h000)
      else $error("channel reset");
   write_flag_hold_a: assert property (!$rose(WRITE_CLOCK) |=>
      $stable(FULL_FLAG_N) && $stable(ALMOST_FULL_N)) else $error("wflag");
   read_side_hold_a: assert property (!$rose(READ_CLOCK) |=>
      $stable({EMPTY_FLAG_N, ALMOST_EMPTY_N, READ_DATA_OUT}))
      else $error("rside");
   read_gate_a: assert property ($rose(READ_CLOCK) &&
      (READ_ENABLE_FIRST_N || READ_ENABLE_SECOND_N) |=>
      $stable(READ_DATA_OUT)) else $error("rgate");
   empty_refuse_a: assert property ($rose(READ_CLOCK) &&
      !EMPTY_FLAG_N && SECOND_ENABLE_OR_LOAD_N |=> $stable(READ_DATA_OUT))
      else $error("empty read");
   full_afull_a: assert property (!FULL_FLAG_N |-> !ALMOST_FULL_N)
      else $error("full map");
   empty_aempty_a: assert property (!EMPTY_FLAG_N |-> !ALMOST_EMPTY_N)
      else $error("empty map");
   drive_follow_a: assert property ($changed(OUTPUT_DRIVE_ENABLE_N) |=>
      READ_DATA_OE_N == $past(OUTPUT_DRIVE_ENABLE_N)) else $error("drive");
endmodule // fsp_dual_fifo_properties
bind fsp_dual_fifo fsp_dual_fifo_properties fsp_props_inst (
   .SYS_CLK, .NRST, .CHANNEL_RESET_N, .WRITE_CLOCK, .READ_CLOCK,
   .SECOND_ENABLE_OR_LOAD_N, .READ_ENABLE_FIRST_N, .READ_ENABLE_SECOND_N,
   .OUTPUT_DRIVE_ENABLE_N, .READ_DATA_OUT, .READ_DATA_OE_N, .FULL_FLAG_N,
   .EMPTY_FLAG_N, .ALMOST_FULL_N, .ALMOST_EMPTY_N);
`default_nettype wire

// *** fsp_fifo_agent.sv ***
// writing and reading agent standing at one fifo channel
`timescale 1ns/1ps
`default_nettype none
module fsp_fifo_agent #(
   parameter logic LD0 = 1'h0
) (
   input wire logic clk,
   output logic wclk,
   output logic rclk,
   output logic we_n,
   output logic ld_n,
   output logic re1_n,
   output logic re2_n,
   output logic [8:0] din,
   input wire logic [8:0] dout
);
   // idle levels; load pin held through reset picks the mode
   initial begin
      {wclk, rclk, we_n, re1_n, re2_n} = 5'h1F;
      din = 9'h000;
      ld_n = LD0;
   end
   // one write event: clock low, then a rise with all held
   task wr(input logic en_n, input logic l, input logic [8:0] d);
      @(posedge clk);
      #1 {wclk, we_n, ld_n, din} = {1'h0, en_n, l, d};
      @(posedge clk);
      #1 wclk = 1'h1;
      @(posedge clk);
      #1 {we_n, din} = {1'h1, ~d}; // released data shows no stale word
   endtask
   // one read event, never overlapping a write
   task rd(input logic [1:0] re, input logic l, output logic [8:0] q);
      @(posedge clk);
      #1 {rclk, re1_n, re2_n, ld_n} = {1'h0, re, l};
      @(posedge clk);
      #1 rclk = 1'h1;
      @(posedge clk);
      #1 q = dout;
      {re1_n, re2_n} = 2'h3;
   endtask
endmodule // fsp_fifo_agent
`default_nettype wire

// *** tb_fsp_dual_fifo.sv ***
// self-checking bench for the dual fifo
`timescale 1ns/1ps
`default_nettype none
module tb_fsp_dual_fifo;
   logic clk, nrst, oe, crst_a;
   wire logic wc, rc, we, ld, r1, r2, wcb, rcb, web, ldb, r1b, r2b;
   wire logic [8:0] din, dinb, q, qb;
   wire logic oen, ff, af, ef, ae, efb;
   wire logic oenb, ffb, afb, aeb;
   int bad_count, checked, cnt, i;
   logic [8:0] r, d;
   logic [8:0] fq[$];
   logic [7:0] v[5];
   // system clock
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   fsp_fifo_agent #(.LD0(1'h0)) agent_a (.clk(clk), .wclk(wc), .rclk(rc),
      .we_n(we), .ld_n(ld), .re1_n(r1), .re2_n(r2), .din(din), .dout(q));
   fsp_fifo_agent #(.LD0(1'h1)) agent_b (.clk(clk), .wclk(wcb), .rclk(rcb),
      .we_n(web), .ld_n(ldb), .re1_n(r1b), .re2_n(r2b), .din(dinb), .dout(qb));
   fsp_dual_fifo #(.DEPTH(16), .AW(4)) fsp_dual_fifo_inst (.SYS_CLK(clk),
      .NRST(nrst), .CHANNEL_RESET_N(crst_a), .WRITE_CLOCK(wc), .READ_CLOCK(rc),
      .PRIMARY_WRITE_ENABLE_N(we), .SECOND_ENABLE_OR_LOAD_N(ld),
      .READ_ENABLE_FIRST_N(r1), .READ_ENABLE_SECOND_N(r2),
      .OUTPUT_DRIVE_ENABLE_N(oe), .WRITE_DATA_IN(din), .READ_DATA_OUT(q),
      .READ_DATA_OE_N(oen), .FULL_FLAG_N(ff), .EMPTY_FLAG_N(ef),
      .ALMOST_FULL_N(af), .ALMOST_EMPTY_N(ae), .CHANNEL_RESET_N_CHAN_B(nrst),
      .WRITE_CLOCK_CHAN_B(wcb), .READ_CLOCK_CHAN_B(rcb),
      .PRIMARY_WRITE_ENABLE_N_CHAN_B(web), .SECOND_ENABLE_OR_LOAD_N_CHAN_B(ldb),
      .READ_ENABLE_FIRST_N_CHAN_B(r1b), .READ_ENABLE_SECOND_N_CHAN_B(r2b),
      .OUTPUT_DRIVE_ENABLE_N_CHAN_B(oe), .WRITE_DATA_IN_CHAN_B(dinb),
      .READ_DATA_OUT_CHAN_B(qb), .READ_DATA_OE_N_CHAN_B(oenb),
      .FULL_FLAG_N_CHAN_B(ffb), .EMPTY_FLAG_N_CHAN_B(efb),
      .ALMOST_FULL_N_CHAN_B(afb), .ALMOST_EMPTY_N_CHAN_B(aeb));
   // compare and count
   task chk(input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task complete_run;
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // expected flag pairs for a word count in a 16-deep array, offsets m, n
   function logic [8:0] wexp(int c, int m);
      return {7'h00, c != 16, c < 16 - m};
   endfunction
   function logic [8:0] rexp(int c, int n);
      return {7'h00, c != 0, c > n};
   endfunction
   // main sequence
   initial begin
      void'($urandom(97));
      {nrst, oe} = 2'h0;
      crst_a = 1'h1;
      repeat (20) @(posedge clk);
      #1 nrst = 1'h1;
      @(posedge clk);
      #1 chk({3'h0, oenb, ff, af, ef, ae, oen}, 9'h018);
      chk(q, 9'h000);
      oe = 1'h1;
      @(posedge clk);
      #1 chk({7'h00, oenb, oen}, 9'h003);
      for (i = 0; i < 4; i++) begin
         agent_a.rd(2'h0, 1'h0, r);
         chk(r, i[0] ? 9'h000 : 9'h007);
      end
      for (i = 0; i < 5; i++) begin
         v[i] = (i == 2) ? 8'h02 : (i == 4) ? 8'h03 : 8'($urandom);
         agent_a.wr(1'h0, 1'h0, {1'h0, v[i]});
      end
      for (i = 1; i < 5; i++) begin
         agent_a.rd(2'h0, 1'h0, r);
         chk(r, {1'h0, v[i]});
      end
      $display("offset test done");
      for (cnt = 1; cnt <= 16; cnt++) begin
         d = 9'($urandom);
         if (cnt == 5)
            agent_a.wr(1'h1, 1'h1, ~d);
         agent_a.wr(1'h0, 1'h1, d);
         fq.push_back(d);
         chk({7'h00, ff, af}, wexp(cnt, 2));
      end
      agent_a.wr(1'h0, 1'h1, 9'h1AA);
      chk({7'h00, ff, af}, wexp(16, 2));
      agent_a.rd(2'h0, 1'h1, r);
      chk({7'h00, ef, ae}, rexp(16, 3));
      for (cnt = 15; cnt >= 0; cnt--) begin
         if (cnt == 9)
            agent_a.rd(2'h1, 1'h1, r);
         agent_a.rd(2'h0, 1'h1, r);
         chk(r, fq.pop_front());
         chk({7'h00, ef, ae}, rexp(cnt, 3));
      end
      d = r;
      agent_a.rd(2'h0, 1'h1, r);
      chk(r, d);
      agent_a.wr(1'h0, 1'h1, 9'h055);
      chk({7'h00, ff, af}, wexp(0, 2));
      $display("stream test done");
      // channel reset in mid-run with load held low keeps offsets mode
      agent_a.rd(2'h3, 1'h0, r);
      crst_a = 1'h0;
      repeat (2) @(posedge clk);
      #1 crst_a = 1'h1;
      @(posedge clk);
      #1 chk({5'h00, ff, af, ef, ae}, 9'h00C);
      chk(q, 9'h000);
      for (i = 0; i < 4; i++) begin
         agent_a.rd(2'h0, 1'h0, r);
         chk(r, i[0] ? 9'h000 : 9'h007);
      end
      $display("channel reset test done");
      d = 9'($urandom);
      agent_b.wr(1'h0, 1'h0, ~d);
      agent_b.wr(1'h0, 1'h1, d);
      agent_b.rd(2'h0, 1'h1, r);
      agent_b.rd(2'h0, 1'h1, r);
      chk(r, d);
      chk({4'h0, oenb, ffb, afb, efb, aeb}, 9'h01C);
      // default offsets of seven on both flags in dual-enable mode
      for (cnt = 1; cnt <= 9; cnt++) begin
         d = 9'($urandom);
         agent_b.wr(1'h0, 1'h1, d);
         fq.push_back(d);
         chk({7'h00, ffb, afb}, wexp(cnt, 7));
      end
      agent_b.rd(2'h0, 1'h1, r);
      chk({7'h00, efb, aeb}, rexp(9, 7));
      for (cnt = 8; cnt >= 0; cnt--) begin
         agent_b.rd(2'h0, 1'h1, r);
         chk(r, fq.pop_front());
         chk({7'h00, efb, aeb}, rexp(cnt, 7));
      end
      $display("dual enable test done");
      complete_run();
   end
endmodule // tb_fsp_dual_fifo
`default_nettype wire
